//--- logic/isa_serial_card_glue_regs.vh
`ifndef ISA_SERIAL_CARD_GLUE_REGS_VH
`define ISA_SERIAL_CARD_GLUE_REGS_VH

// Window geometry
`define WINDOW_SIZE          8
`define BASE_ADDR_MSB        9
`define BASE_ADDR_LSB        3

// Window offsets of each port
`define CHAN_A_DATA_PORT     3'h0
`define CHAN_A_CONTROL_PORT  3'h1
`define CHAN_B_DATA_PORT     3'h2
`define CHAN_B_CONTROL_PORT  3'h3
`define BOARD_CONTROL_STATUS 3'h4

// Board control/status fields
`define BCS_TERM_READY_A     0
`define BCS_TERM_READY_B     1
`define BCS_DMA_ENABLE       7
`define BCS_RESET            8'h00
`define BCS_DMA_ENABLE_RESET 1'b0

// Synchroniser idle levels of the controller requests and the host acknowledges
`define REQ_IDLE             4'hf
`define LINE_IDLE            4'hc

// Answer on window locations with no port behind them
`define UNUSED_READ_VALUE    8'h00

// Pin synchroniser reset values
`define STROBE_IDLE          3'h7

// Interrupt line count (2/9, 3, 4, 5, 7, 10, 11, 12, 15)
`define IRQ_LINES            9

`endif

//--- logic/pin_sync.v
`timescale 1ns/100ps
`default_nettype none

// Three-stage pin synchroniser; the output only moves once stages two and
// three agree, which rejects a one-cycle glitch caught at the edge.
module pin_sync
#(
  parameter WIDTH     = 1,
  parameter RESET_VAL = 0
)
(
  input  wire             sys_clk,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] pin,
  output reg  [WIDTH-1:0] level
);

  localparam [WIDTH-1:0] INIT = RESET_VAL;

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;

  genvar i;

  // Stage one feeds only stage two
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : bit_sync
      always @(posedge sys_clk)
      begin
        if (!reset_n)
        begin
          stage1[i] <= INIT[i];
          stage2[i] <= INIT[i];
          stage3[i] <= INIT[i];
          level[i]  <= INIT[i];
        end
        else
        begin
          stage1[i] <= pin[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          if (stage2[i] == stage3[i])
            level[i] <= stage3[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

//--- logic/window_decode.v
`timescale 1ns/100ps
`default_nettype none
`include "isa_serial_card_glue_regs.vh"

// Eight-location window decode against the base-select switches
module window_decode
(
  input  wire [9:0] host_addr,
  input  wire       host_aen,
  input  wire [6:0] base_select_switch,
  output wire       hit,
  output wire [2:0] offset
);

  // Closed switch (1) demands a zero, open switch (0) demands a one
  wire [6:0] want = ~base_select_switch;

  // AEN high marks a DMA cycle, where the address does not belong to us
  assign hit    = !host_aen && (host_addr[`BASE_ADDR_MSB:`BASE_ADDR_LSB] == want);
  assign offset = host_addr[`BASE_ADDR_LSB-1:0];

endmodule
`default_nettype wire

//--- logic/isa_serial_card_glue.v
`timescale 1ns/100ps
`default_nettype none
`include "isa_serial_card_glue_regs.vh"

// Behaviour
// - Card answers exactly eight consecutive I/O addresses from a switch-set base.
// - Address bits 9..3 compare against seven switches; bits 2..0 pick the location.
// - Closed switch needs a zero address bit, open switch needs a one.
// - Offset 0 reaches channel A data, offset 1 channel A control.
// - Offset 2 reaches channel B data, offset 3 channel B control.
// - Offset 4 reaches the board control/status port, not the controller.
// - Interrupt drives exactly one configured IRQ line of the nine choices.
// - With no IRQ line configured, every IRQ line stays undriven.
// - Interrupt works in normal dedicated mode or in shared mode.
// - Full duplex lets channel A use two DMA channels at once.
// - Half duplex uses one DMA channel, 1 or 3, from wait/request.
// - Full duplex: receive on wait/request, transmit on ready/request, channels 1 and 3.
// - DMA transfers qualify with the acknowledge of the selected channel.
// - Permanent-enable option keeps DMA drivers enabled always.
// - Software option makes DMA drivers follow control/status bit 7.
// - With no enable option, DMA drivers stay off and no DMA occurs.
// - Reset clears the software DMA enable bit.
// - With permanent enable, the software bit has no effect on drivers.
// - Receive clock path selectable straight or inverted.
// - Transmit clock path selectable straight or inverted.
// - Transmit clock has its own enable; off blocks it from the controller.
// - Bits 0,1 write terminal-ready outputs; reads return the data-set-ready inputs.
module isa_serial_card_glue
(
  input  wire       sys_clk,
  input  wire       reset_n,
  // Host bus
  input  wire [9:0] host_addr,
  input  wire       host_aen,
  input  wire       host_ior_n,
  input  wire       host_iow_n,
  input  wire [7:0] host_data_in,
  output reg  [7:0] host_data_out,
  output reg        host_data_oe,
  output reg  [8:0] host_irq_out,
  output reg  [8:0] host_irq_oe,
  output reg        host_drq1_out,
  output reg        host_drq1_oe,
  output reg        host_drq3_out,
  output reg        host_drq3_oe,
  input  wire       host_dack1_n,
  input  wire       host_dack3_n,
  // Straps
  input  wire [6:0] base_select_switch,
  input  wire [8:0] irq_select_header,
  input  wire       irq_shared_mode,
  input  wire       dma_full_duplex,
  input  wire       dma_half_on_ch3,
  input  wire       dma_rx_on_ch1,
  input  wire       dma_perm_enable,
  input  wire       dma_sw_control,
  input  wire       rx_clock_inverted,
  input  wire       tx_clock_inverted,
  input  wire       tx_clock_gate_on,
  // Serial controller side
  output reg        scc_cs_n,
  output reg        scc_rd_n,
  output reg        scc_wr_n,
  output reg        scc_chan_a,
  output reg        scc_data_sel,
  output reg  [7:0] scc_wdata,
  input  wire [7:0] scc_rdata,
  input  wire       scc_int_n,
  input  wire       scc_wait_req_n,
  input  wire       scc_dtr_req_n,
  output reg        scc_dack_n,
  // Serial clocks and modem lines
  input  wire       rx_clock_in,
  input  wire       tx_clock_in,
  output reg        rx_clock_to_scc,
  output reg        tx_clock_to_scc,
  output reg        term_ready_a,
  output reg        term_ready_b,
  input  wire       data_set_ready_a,
  input  wire       data_set_ready_b
);

  // Synchronised pins
  wire [9:0]  addr_s;
  wire [7:0]  wdata_s;
  wire [7:0]  rdata_s;
  wire [2:0]  strobe_s;
  wire [3:0]  req_s;
  wire [3:0]  line_s;
  wire [6:0]  switch_s;
  wire [8:0]  irq_hdr_s;
  wire [9:0]  strap_s;

  wire        aen_s     = strobe_s[2];
  wire        ior_s     = ~strobe_s[1];
  wire        iow_s     = ~strobe_s[0];
  wire        int_s     = ~req_s[3];
  wire        wait_req  = ~req_s[2];
  wire        dtr_req   = ~req_s[1];
  wire        dack1     = ~line_s[3];
  wire        dack3     = ~line_s[2];
  wire        dsr_a     = line_s[1];
  wire        dsr_b     = line_s[0];
  wire        shared    = strap_s[9];
  wire        full_dup  = strap_s[8];
  wire        half_ch3  = strap_s[7];
  wire        rx_ch1    = strap_s[6];
  wire        perm_en   = strap_s[5];
  wire        sw_ctrl   = strap_s[4];
  wire        rx_inv    = strap_s[3];
  wire        tx_inv    = strap_s[2];
  wire        tx_gate   = strap_s[1];
  wire        rx_clk_s  = strap_s[0];
  wire        tx_clk_s;

  wire        hit;
  wire [2:0]  offset;

  // Software DMA enable and its derived driver enable
  reg         dma_sw_enable;
  wire        dma_drivers_on;
  // DMA channel routing
  wire        ch1_req;
  wire        ch3_req;
  wire        ch1_used;
  wire        ch3_used;
  wire        dma_ack;
  // Interrupt line selection
  wire [8:0]  irq_sel;
  wire [9:0]  lower_set;

  pin_sync #(.WIDTH(10), .RESET_VAL(0)) u_addr_sync
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin     (host_addr),
    .level   (addr_s)
  );

  pin_sync #(.WIDTH(8), .RESET_VAL(0)) u_wdata_sync
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin     (host_data_in),
    .level   (wdata_s)
  );

  pin_sync #(.WIDTH(8), .RESET_VAL(0)) u_rdata_sync
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin     (scc_rdata),
    .level   (rdata_s)
  );

  // AEN resets high so nothing decodes before the bus is seen
  pin_sync #(.WIDTH(3), .RESET_VAL(`STROBE_IDLE)) u_strobe_sync
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin     ({host_aen, host_ior_n, host_iow_n}),
    .level   (strobe_s)
  );

  pin_sync #(.WIDTH(4), .RESET_VAL(`REQ_IDLE)) u_req_sync
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin     ({scc_int_n, scc_wait_req_n, scc_dtr_req_n, tx_clock_in}),
    .level   ({req_s[3:1], tx_clk_s})
  );
  assign req_s[0] = 1'b1;

  pin_sync #(.WIDTH(4), .RESET_VAL(`LINE_IDLE)) u_line_sync
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin     ({host_dack1_n, host_dack3_n, data_set_ready_a, data_set_ready_b}),
    .level   (line_s)
  );

  // Straps are static but still cross in through the same filter
  pin_sync #(.WIDTH(26), .RESET_VAL(0)) u_strap_sync
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin     ({base_select_switch, irq_select_header, irq_shared_mode,
               dma_full_duplex, dma_half_on_ch3, dma_rx_on_ch1, dma_perm_enable,
               dma_sw_control, rx_clock_inverted, tx_clock_inverted,
               tx_clock_gate_on, rx_clock_in}),
    .level   ({switch_s, irq_hdr_s, strap_s})
  );

  window_decode u_decode
  (
    .host_addr          (addr_s),
    .host_aen           (aen_s),
    .base_select_switch (switch_s),
    .hit                (hit),
    .offset             (offset)
  );

  // Drivers on by jumper, or by software bit under the software jumper
  assign dma_drivers_on = perm_en | (sw_ctrl & dma_sw_enable);

  // Half duplex sends wait/request to one channel; full duplex splits rx/tx
  assign ch1_req = full_dup ? (rx_ch1 ? wait_req : dtr_req)
                            : (!half_ch3 & wait_req);
  assign ch3_req = full_dup ? (rx_ch1 ? dtr_req : wait_req)
                            : (half_ch3 & wait_req);
  assign ch1_used = full_dup | !half_ch3;
  assign ch3_used = full_dup | half_ch3;

  // Only the acknowledge of a channel we actually route counts
  assign dma_ack = dma_drivers_on & ((ch1_used & dack1) | (ch3_used & dack3));

  // Lowest fitted jumper wins so at most one line is ever driven
  assign lower_set[0] = 1'b0;
  genvar k;
  generate
    for (k = 0; k < `IRQ_LINES; k = k + 1)
    begin : irq_pick
      assign irq_sel[k]     = irq_hdr_s[k] & !lower_set[k];
      assign lower_set[k+1] = lower_set[k] | irq_hdr_s[k];
    end
  endgenerate

  // Board control/status register; DTR bits and software DMA enable
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      dma_sw_enable <= `BCS_DMA_ENABLE_RESET;
      term_ready_a  <= 1'b0;
      term_ready_b  <= 1'b0;
    end
    else if (iow_s && hit && (offset == `BOARD_CONTROL_STATUS))
    begin
      term_ready_a  <= wdata_s[`BCS_TERM_READY_A];
      term_ready_b  <= wdata_s[`BCS_TERM_READY_B];
      dma_sw_enable <= wdata_s[`BCS_DMA_ENABLE];
    end
  end

  // Controller strobes: window offsets 0-3, or a DMA cycle to channel A data
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      scc_cs_n     <= 1'b1;
      scc_rd_n     <= 1'b1;
      scc_wr_n     <= 1'b1;
      scc_chan_a   <= 1'b1;
      scc_data_sel <= 1'b1;
      scc_wdata    <= 8'h00;
      scc_dack_n   <= 1'b1;
    end
    else
    begin
      scc_wdata  <= wdata_s;
      scc_dack_n <= !dma_ack;
      if (dma_ack && aen_s && (ior_s || iow_s))
      begin
        // DMA moves channel A data only
        scc_cs_n     <= 1'b0;
        scc_chan_a   <= 1'b1;
        scc_data_sel <= 1'b1;
        scc_rd_n     <= !ior_s;
        scc_wr_n     <= !iow_s;
      end
      else if (hit && !offset[2] && (ior_s || iow_s))
      begin
        scc_cs_n     <= 1'b0;
        scc_chan_a   <= !offset[1];
        scc_data_sel <= !offset[0];
        scc_rd_n     <= !ior_s;
        scc_wr_n     <= !iow_s;
      end
      else
      begin
        scc_cs_n <= 1'b1;
        scc_rd_n <= 1'b1;
        scc_wr_n <= 1'b1;
      end
    end
  end

  // Read return; unused window slots still answer so the window is eight wide
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      host_data_out <= 8'h00;
      host_data_oe  <= 1'b0;
    end
    else
    begin
      host_data_oe <= ior_s && (hit || (dma_ack && aen_s));
      if (dma_ack && aen_s)
        host_data_out <= rdata_s;
      else if (!offset[2])
        host_data_out <= rdata_s;
      else if (offset == `BOARD_CONTROL_STATUS)
        host_data_out <= {6'h00, dsr_b, dsr_a};
      else
        host_data_out <= `UNUSED_READ_VALUE;
    end
  end

  // Interrupt routing; shared mode releases the line when idle
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      host_irq_out <= 9'h000;
      host_irq_oe  <= 9'h000;
    end
    else
    begin
      host_irq_out <= irq_sel & {`IRQ_LINES{int_s}};
      if (shared)
        host_irq_oe <= irq_sel & {`IRQ_LINES{int_s}};
      else
        host_irq_oe <= irq_sel;
    end
  end

  // DMA request drivers; tri-stated unless enabled and routed
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      host_drq1_out <= 1'b0;
      host_drq1_oe  <= 1'b0;
      host_drq3_out <= 1'b0;
      host_drq3_oe  <= 1'b0;
    end
    else
    begin
      host_drq1_out <= dma_drivers_on & ch1_req;
      host_drq1_oe  <= dma_drivers_on & ch1_used;
      host_drq3_out <= dma_drivers_on & ch3_req;
      host_drq3_oe  <= dma_drivers_on & ch3_used;
    end
  end

  // Serial clock paths; oversampled, so a few cycles of delay is the cost
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      rx_clock_to_scc <= 1'b0;
      tx_clock_to_scc <= 1'b0;
    end
    else
    begin
      rx_clock_to_scc <= rx_clk_s ^ rx_inv;
      tx_clock_to_scc <= tx_gate & (tx_clk_s ^ tx_inv);
    end
  end

endmodule
`default_nettype wire

//--- bench/isa_serial_card_glue_properties.sv
`timescale 1ns/100ps
`default_nettype none
// Pin-level watch on decode, interrupt, DMA and clock paths of the card
module isa_serial_card_glue_properties
(
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic [9:0] host_addr,
  input wire logic       host_aen,
  input wire logic [6:0] base_select_switch,
  input wire logic       host_data_oe,
  input wire logic       scc_cs_n,
  input wire logic [8:0] irq_select_header,
  input wire logic       irq_shared_mode,
  input wire logic       scc_int_n,
  input wire logic [8:0] host_irq_oe,
  input wire logic       dma_perm_enable,
  input wire logic       dma_sw_control,
  input wire logic       dma_full_duplex,
  input wire logic       host_drq1_oe,
  input wire logic       host_drq3_oe,
  input wire logic       scc_dack_n,
  input wire logic       host_dack1_n,
  input wire logic       host_dack3_n,
  input wire logic       rx_clock_in,
  input wire logic       rx_clock_inverted,
  input wire logic       rx_clock_to_scc,
  input wire logic       tx_clock_gate_on,
  input wire logic       tx_clock_to_scc
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Seven cycles cover the pin synchroniser plus the output register
  sequence window_miss;
    (!host_aen && host_addr[9:3] != ~base_select_switch)[*7];
  endsequence
  sequence rx_steady;
    ($stable(rx_clock_in) && $stable(rx_clock_inverted))[*7];
  endsequence
  chk_miss_quiet: assert property (window_miss |-> !host_data_oe && scc_cs_n)
    else $error("card answered outside its window");
  chk_irq_onehot: assert property ($onehot0(host_irq_oe))
    else $error("more than one interrupt line driven");
  chk_irq_none: assert property ((irq_select_header == 9'h000)[*7] |-> host_irq_oe == 9'h000)
    else $error("interrupt line driven with no line chosen");
  chk_shared_idle: assert property ((irq_shared_mode && scc_int_n)[*7] |-> host_irq_oe == 9'h000)
    else $error("shared interrupt line held without a request");
  chk_dma_off: assert property ((!dma_perm_enable && !dma_sw_control)[*7]
    |-> !host_drq1_oe && !host_drq3_oe && scc_dack_n)
    else $error("DMA drivers active with no enable option");
  chk_perm_full: assert property ((dma_perm_enable && dma_full_duplex)[*7]
    |-> host_drq1_oe && host_drq3_oe)
    else $error("permanent enable did not drive both DMA channels");
  chk_dack_qual: assert property ((host_dack1_n && host_dack3_n)[*7] |-> scc_dack_n)
    else $error("controller acknowledge without host acknowledge");
  chk_rx_path: assert property (rx_steady |-> rx_clock_to_scc == (rx_clock_in ^ rx_clock_inverted))
    else $error("receive clock path wrong");
  chk_tx_gate: assert property ((!tx_clock_gate_on)[*7] |-> !tx_clock_to_scc)
    else $error("transmit clock passed while gated off");
endmodule

bind isa_serial_card_glue isa_serial_card_glue_properties isa_serial_card_glue_properties_inst (.*);
`default_nettype wire

//--- bench/host_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host bus side: programmed I/O cycles and DMA acknowledge cycles
module host_bus_model
(
  input  wire logic       sys_clk,
  input  wire logic       host_drq1_out,
  input  wire logic       host_drq3_out,
  output logic      [9:0] host_addr,
  output logic            host_aen,
  output logic            host_ior_n,
  output logic            host_iow_n,
  output logic      [7:0] host_data_in,
  output logic            host_dack1_n,
  output logic            host_dack3_n
);
  // Idle bus at time zero
  initial
  begin
    host_addr = 10'h000;
    host_data_in = 8'h00;
    {host_aen, host_ior_n, host_iow_n, host_dack1_n, host_dack3_n} = 5'h0f;
  end

  // One I/O cycle; hold stretches the strobe to play a slow host
  task automatic io(input logic wr, input logic [9:0] a, input logic [7:0] d, input int hold);
    @(posedge sys_clk);
    #1;
    host_addr = a;
    host_data_in = wr ? d : ~host_data_in;
    repeat (5) @(posedge sys_clk);
    #1;
    if (wr) host_iow_n = 1'b0;
    else host_ior_n = 1'b0;
    repeat (hold) @(posedge sys_clk);
    #1;
    {host_iow_n, host_ior_n} = 2'b11;
    repeat (6) @(posedge sys_clk);
    #1;
    host_data_in = ~host_data_in; // Released data shows no stale value
  endtask

  // DMA read from the card; acknowledge once that channel requests, or after 50 cycles without a request
  task automatic dma(input logic ch3);
    int n;
    n = 0;
    while ((ch3 ? host_drq3_out : host_drq1_out) !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    #1;
    {host_aen, host_ior_n, host_dack3_n, host_dack1_n} = {2'b10, !ch3, ch3};
    repeat (8) @(posedge sys_clk);
    #1;
    {host_aen, host_ior_n, host_dack3_n, host_dack1_n} = 4'h7;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

//--- bench/isa_serial_card_glue_test.sv
`timescale 1ns/100ps
`default_nettype none
module isa_serial_card_glue_test;
  logic        sys_clk = 1'b0, reset_n = 1'b0;
  logic [9:0]  host_addr, base;
  logic        host_aen, host_ior_n, host_iow_n, host_dack1_n, host_dack3_n;
  logic [7:0]  host_data_in, host_data_out, scc_wdata;
  logic [8:0]  host_irq_out, host_irq_oe;
  logic        host_data_oe, host_drq1_out, host_drq1_oe, host_drq3_out, host_drq3_oe;
  logic        scc_cs_n, scc_rd_n, scc_wr_n, scc_chan_a, scc_data_sel, scc_dack_n;
  logic        rx_clock_to_scc, tx_clock_to_scc, term_ready_a, term_ready_b;
  logic [6:0]  base_select_switch = 7'h00;
  logic [8:0]  irq_select_header = 9'h000;
  logic [7:0]  scc_rdata = 8'h00;
  logic        irq_shared_mode = 0, dma_full_duplex = 0, dma_half_on_ch3 = 0;
  logic        dma_rx_on_ch1 = 0, dma_perm_enable = 0, dma_sw_control = 0;
  logic        rx_clock_inverted = 0, tx_clock_inverted = 0, tx_clock_gate_on = 0;
  logic        scc_int_n = 1, scc_wait_req_n = 1, scc_dtr_req_n = 1, rx_clock_in = 0;
  logic        tx_clock_in = 0, data_set_ready_a = 0, data_set_ready_b = 0;
  logic        prev_wr = 1'b1, prev_oe = 1'b0;
  logic [31:0] seed = 32'h95a4fc70;
  logic [10:0] exp_q[$];
  int          failures = 0, num_checks = 0, cycles = 0;

  isa_serial_card_glue isa_serial_card_glue_inst (.*);
  host_bus_model host_bus_model_inst (.*);

  always #2 sys_clk = ~sys_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task check(input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task check_next(input logic [10:0] seen);
    if (exp_q.size() == 0) check(seen, (seen === 11'h000) ? 11'h7ff : 11'h000);
    else check(seen, exp_q.pop_front());
  endtask

  task settle;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Scoreboard: each write strobe or read-drive onset takes the oldest note
  always @(negedge sys_clk)
  begin
    if (!scc_wr_n && prev_wr) check_next({1'b0, scc_chan_a, scc_data_sel, scc_wdata});
    if (host_data_oe && !prev_oe) check_next({3'b100, host_data_out});
    prev_wr = scc_wr_n;
    prev_oe = host_data_oe;
  end

  // A hang ends the run through the same report
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      end_of_test;
    end
  end

  initial
  begin
    repeat (2) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    settle;
    check({7'h0, term_ready_b, term_ready_a, host_drq1_oe, host_drq3_oe}, 11'h000);
    $display("reset test done");
    seed = lfsr(seed);
    base_select_switch = seed[6:0];
    base = {~base_select_switch, 3'h0};
    settle;
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      exp_q.push_back({1'b0, i < 2, ~i[0], seed[7:0]});
      host_bus_model_inst.io(1'b1, base | 10'(i), seed[7:0], 6 + i);
    end
    host_bus_model_inst.io(1'b1, base ^ 10'h008, 8'h5a, 6); // Miss: no note queued
    $display("window test done");
    {data_set_ready_b, data_set_ready_a} = 2'b10;
    host_bus_model_inst.io(1'b1, base | 10'h004, 8'h03, 6);
    check({9'h0, term_ready_b, term_ready_a}, 11'h003);
    for (int i = 4; i < 8; i++)
    begin
      exp_q.push_back({3'b100, (i == 4) ? 8'h02 : 8'h00});
      host_bus_model_inst.io(1'b0, base | 10'(i), 8'h00, 8);
    end
    $display("board port test done");
    {dma_sw_control, dma_full_duplex, dma_rx_on_ch1, scc_wait_req_n} = 4'he;
    settle;
    check({9'h0, host_drq1_oe, host_drq3_oe}, 11'h000);
    host_bus_model_inst.io(1'b1, base | 10'h004, 8'h80, 6);
    settle;
    check({7'h0, host_drq1_oe, host_drq3_oe, host_drq1_out, host_drq3_out}, 11'h00e);
    seed = lfsr(seed);
    scc_rdata = seed[7:0];
    exp_q.push_back({3'b100, seed[7:0]});
    fork
      host_bus_model_inst.dma(1'b0);
      begin
        repeat (8) @(negedge sys_clk);
        check({6'h0, scc_dack_n, scc_rd_n, scc_cs_n, scc_chan_a, scc_data_sel}, 11'h003);
      end
    join
    host_bus_model_inst.io(1'b1, base | 10'h004, 8'h00, 6);
    settle;
    check({9'h0, host_drq1_oe, host_drq3_oe}, 11'h000);
    dma_perm_enable = 1'b1;
    host_bus_model_inst.io(1'b1, base | 10'h004, 8'h00, 6);
    settle;
    check({9'h0, host_drq1_oe, host_drq3_oe}, 11'h003);
    dma_rx_on_ch1 = 1'b0;
    settle;
    check({9'h0, host_drq1_out, host_drq3_out}, 11'h001);
    {dma_full_duplex, dma_half_on_ch3} = 2'b01;
    settle;
    check({8'h0, host_drq1_oe, host_drq3_oe, host_drq3_out}, 11'h003);
    {dma_perm_enable, dma_sw_control} = 2'b00;
    settle;
    check({9'h0, host_drq1_oe, host_drq3_oe}, 11'h000);
    $display("dma test done");
    scc_int_n = 1'b0;
    for (int i = 0; i < 18; i++)
    begin
      irq_shared_mode = i > 8;
      irq_select_header = 9'h001 << (i % 9);
      settle;
      check({2'b00, host_irq_oe & host_irq_out}, {2'b00, irq_select_header});
    end
    scc_int_n = 1'b1;
    settle;
    check({2'b00, host_irq_oe}, 11'h000);
    irq_shared_mode = 1'b0;
    settle;
    check({2'b00, host_irq_oe}, {2'b00, irq_select_header});
    check({2'b00, host_irq_out}, 11'h000);
    {irq_select_header, irq_shared_mode, scc_int_n} = 11'h000;
    settle;
    check({2'b00, host_irq_oe}, 11'h000);
    $display("interrupt test done");
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      {rx_clock_in, tx_clock_in} = seed[1:0];
      {rx_clock_inverted, tx_clock_inverted, tx_clock_gate_on} = i[2:0];
      settle;
      check({9'h0, rx_clock_to_scc, tx_clock_to_scc}, {9'h0, rx_clock_in ^ rx_clock_inverted,
        tx_clock_gate_on & (tx_clock_in ^ tx_clock_inverted)});
    end
    $display("clock path test done");
    check({10'h0, exp_q.size() == 0}, 11'h001);
    end_of_test;
  end
endmodule
`default_nettype wire
